/* design/ief_pkg.sv */
// Package with register map, bit positions and reset values of the interrupt enable/flag block
package ief_pkg;
  // ----------------------------------------
  // Register byte addresses on APB
  // ----------------------------------------
  localparam logic [11:0] IEF_ADDR_INTERRUPT_CONTROL = 12'h000;
  localparam logic [11:0] IEF_ADDR_PERIPH_IRQ_ENABLE = 12'h004;
  localparam logic [11:0] IEF_ADDR_PERIPH_IRQ_FLAGS = 12'h008;
  localparam logic [11:0] IEF_ADDR_PIN_CHANGE_MASK = 12'h00C;
  localparam logic [11:0] IEF_ADDR_EXT_EDGE_SELECT = 12'h010;
  localparam int IEF_ADDR_W = 12;
  localparam int IEF_REG_W = 8;
  localparam int IEF_PORT_W = 6;

  // ----------------------------------------
  // Core interrupt control fields
  // ----------------------------------------
  localparam int IEF_GLOBAL_EN_BIT = 7;
  localparam int IEF_PERIPH_GRP_EN_BIT = 6;
  localparam int IEF_TICK_OVF_EN_BIT = 5;
  localparam int IEF_EXT_PIN_EN_BIT = 4;
  localparam int IEF_PORT_CHG_EN_BIT = 3;
  localparam int IEF_TICK_OVF_FLAG_BIT = 2;
  localparam int IEF_EXT_PIN_FLAG_BIT = 1;
  localparam int IEF_PORT_CHG_FLAG_BIT = 0;

  // ----------------------------------------
  // Peripheral enable / flag fields
  // ----------------------------------------
  localparam int IEF_CONV_DONE_BIT = 6;
  localparam int IEF_CAPCMP_BIT = 5;
  localparam int IEF_CMP_TWO_BIT = 4;
  localparam int IEF_CMP_ONE_BIT = 3;
  localparam int IEF_PERIOD_MATCH_BIT = 1;
  localparam int IEF_WIDE_OVF_BIT = 0;
  localparam logic [7:0] IEF_PERIPH_MASK_FULL = 8'h7B;
  localparam logic [7:0] IEF_PERIPH_MASK_REDUCED = 8'h19;

  localparam logic [7:0] IEF_RESET_BYTE = 8'h00;
  localparam logic [5:0] IEF_RESET_PORT = 6'h00;
  localparam logic [31:0] IEF_READ_ZERO = 32'h0000_0000;

  // Capture/compare unit modes
  localparam logic [1:0] IEF_CCP_CAPTURE = 2'h0;
  localparam logic [1:0] IEF_CCP_COMPARE = 2'h1;
  localparam logic [1:0] IEF_CCP_PWM = 2'h2;
endpackage : ief_pkg

/* design/ief_irq_enable_flag_logic.sv */
// Interrupt enable and flag registers with APB slave and core request output
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Global enable bit 7 lets unmasked sources interrupt; zero blocks everything.
// - Peripheral group enable bit 6 gates all peripheral interrupts.
// - Bit 5 enables the tick timer overflow interrupt.
// - Bit 4 enables the external pin interrupt.
// - Bit 3 enables port change interrupt; at least one pin change mask bit must be set.
// - Bit 2 set on tick timer rollover, cleared only by software.
// - Bit 1 set on external pin event, cleared only by software.
// - Bit 0 set when any of port pins 5..0 changes, software clears.
// - Flags set regardless of own enable or global enable.
// - Peripheral interrupts need group enable plus individual enable.
// - Peripheral enables at bits 6,5,4,3,1,0 as listed.
// - Bits 7 and 2 of peripheral registers read zero.
// - Conversion done flag bit 6 set on conversion complete.
// - Capture/compare flag bit 5 on capture or compare event; unused in PWM.
// - Comparator flags bits 4 and 3 set on output change, software clears.
// - Period match flag bit 1 set on timer two match, software clears.
// - Wide timer overflow flag bit 0 set on overflow, software clears.
// - Reduced variant drops converter, capture/compare and timer two bits.
// - External flag on rising edge when edge select is 1, else falling.
module ief_irq_enable_flag_logic
  import ief_pkg::*;
#(
  parameter bit REDUCED_VARIANT = 1'b0
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [IEF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tickTimerRollover,
  input wire logic extIrqPin,
  input wire logic [IEF_PORT_W-1:0] firstIoPort,
  input wire logic convDone,
  input wire logic [1:0] capcmpMode,
  input wire logic capcmpEvent,
  input wire logic comparatorOneOut,
  input wire logic comparatorTwoOut,
  input wire logic periodMatch,
  input wire logic wideTimerOverflow,
  output logic coreIrqReq
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (IEF_REG_W != 8)
  begin : g_width_chk
    $error("register width must be eight bits");
  end

  localparam logic [7:0] PERIPH_MASK = REDUCED_VARIANT ? IEF_PERIPH_MASK_REDUCED
                                                       : IEF_PERIPH_MASK_FULL;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Asynchronous pins pass two flops; comparator outputs come from analog.
  logic extMeta_reg, extSync_reg, extPrev_reg;
  logic [IEF_PORT_W-1:0] portMeta_reg, portSync_reg, portPrev_reg;
  logic [1:0] cmpMeta_reg, cmpSync_reg, cmpPrev_reg;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      extMeta_reg <= 1'b0;
      extSync_reg <= 1'b0;
      portMeta_reg <= IEF_RESET_PORT;
      portSync_reg <= IEF_RESET_PORT;
      cmpMeta_reg <= 2'h0;
      cmpSync_reg <= 2'h0;
    end
    else
    begin
      extMeta_reg <= extIrqPin;
      extSync_reg <= extMeta_reg;
      portMeta_reg <= firstIoPort;
      portSync_reg <= portMeta_reg;
      cmpMeta_reg <= {comparatorTwoOut, comparatorOneOut};
      cmpSync_reg <= cmpMeta_reg;
    end
  end

  // Event detection is blocked only in the first cycle after reset; a pin that is
  // high at the release of reset still looks like a pin change two cycles later.
  logic primed_reg;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      primed_reg <= 1'b0;
      extPrev_reg <= 1'b0;
      portPrev_reg <= IEF_RESET_PORT;
      cmpPrev_reg <= 2'h0;
    end
    else
    begin
      primed_reg <= 1'b1;
      extPrev_reg <= extSync_reg;
      portPrev_reg <= portSync_reg;
      cmpPrev_reg <= cmpSync_reg;
    end
  end

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic wrAcc, rdSetup, mapped;
  logic [7:0] wrByte;
  assign wrByte = pwdata[7:0];
  assign mapped = (paddr == IEF_ADDR_INTERRUPT_CONTROL) || (paddr == IEF_ADDR_PERIPH_IRQ_ENABLE) ||
                  (paddr == IEF_ADDR_PERIPH_IRQ_FLAGS) || (paddr == IEF_ADDR_PIN_CHANGE_MASK) ||
                  (paddr == IEF_ADDR_EXT_EDGE_SELECT);
  assign wrAcc = psel && penable && pwrite;
  assign rdSetup = psel && !penable && !pwrite;
  // Zero wait states; an unmapped address answers with an error.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  function automatic logic wrHit(input logic [IEF_ADDR_W-1:0] a, input logic w,
                                 input logic [IEF_ADDR_W-1:0] target);
    wrHit = w && (a == target);
  endfunction : wrHit

  logic wrCtrl, wrPerEn, wrPerFlag, wrMask, wrEdge;
  assign wrCtrl = wrHit(paddr, wrAcc, IEF_ADDR_INTERRUPT_CONTROL);
  assign wrPerEn = wrHit(paddr, wrAcc, IEF_ADDR_PERIPH_IRQ_ENABLE);
  assign wrPerFlag = wrHit(paddr, wrAcc, IEF_ADDR_PERIPH_IRQ_FLAGS);
  assign wrMask = wrHit(paddr, wrAcc, IEF_ADDR_PIN_CHANGE_MASK);
  assign wrEdge = wrHit(paddr, wrAcc, IEF_ADDR_EXT_EDGE_SELECT);

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  logic tickEvt, extEvt, portEvt, capcmpEvt;
  logic [IEF_PORT_W-1:0] pinChangeMask_reg;
  logic extEdgeSelect_reg;
  logic [1:0] cmpEvt;
  assign tickEvt = tickTimerRollover;
  assign extEvt = primed_reg && (extEdgeSelect_reg ? (extSync_reg && !extPrev_reg)
                                                   : (!extSync_reg && extPrev_reg));
  // Any change of pins 5..0 sets the flag; the mask only gates the request.
  assign portEvt = primed_reg && (portSync_reg != portPrev_reg);
  assign cmpEvt = primed_reg ? (cmpSync_reg ^ cmpPrev_reg) : 2'h0;
  assign capcmpEvt = capcmpEvent && (capcmpMode != IEF_CCP_PWM);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinChangeMask_reg <= IEF_RESET_PORT;
      extEdgeSelect_reg <= 1'b0;
    end
    else
    begin
      if (wrMask)
        pinChangeMask_reg <= wrByte[IEF_PORT_W-1:0];
      if (wrEdge)
        extEdgeSelect_reg <= wrByte[0];
    end
  end

  // ----------------------------------------
  // Core interrupt control register
  // ----------------------------------------
  logic [7:0] intCtrl_reg, intCtrl_next;
  always_comb
  begin
    intCtrl_next = intCtrl_reg;
    if (wrCtrl)
      intCtrl_next = wrByte;
    // Hardware set wins over a software clear in the same cycle.
    if (tickEvt)
      intCtrl_next[IEF_TICK_OVF_FLAG_BIT] = 1'b1;
    if (extEvt)
      intCtrl_next[IEF_EXT_PIN_FLAG_BIT] = 1'b1;
    if (portEvt)
      intCtrl_next[IEF_PORT_CHG_FLAG_BIT] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      intCtrl_reg <= IEF_RESET_BYTE;
    else
      intCtrl_reg <= intCtrl_next;
  end

  // ----------------------------------------
  // Peripheral enable and flag registers
  // ----------------------------------------
  logic [7:0] perEn_reg, perFlag_reg, perFlag_next, perEvt;
  always_comb
  begin
    perEvt = IEF_RESET_BYTE;
    perEvt[IEF_CONV_DONE_BIT] = convDone;
    perEvt[IEF_CAPCMP_BIT] = capcmpEvt;
    perEvt[IEF_CMP_TWO_BIT] = cmpEvt[1];
    perEvt[IEF_CMP_ONE_BIT] = cmpEvt[0];
    perEvt[IEF_PERIOD_MATCH_BIT] = periodMatch;
    perEvt[IEF_WIDE_OVF_BIT] = wideTimerOverflow;
    perFlag_next = wrPerFlag ? wrByte : perFlag_reg;
    perFlag_next = (perFlag_next | perEvt) & PERIPH_MASK;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      perEn_reg <= IEF_RESET_BYTE;
      perFlag_reg <= IEF_RESET_BYTE;
    end
    else
    begin
      if (wrPerEn)
        perEn_reg <= wrByte & PERIPH_MASK;
      perFlag_reg <= perFlag_next;
    end
  end

  // ----------------------------------------
  // Core request
  // ----------------------------------------
  logic coreSrc, periphSrc;
  logic portPinArmed;
  assign portPinArmed = |pinChangeMask_reg;
  assign coreSrc = (intCtrl_reg[IEF_TICK_OVF_EN_BIT] && intCtrl_reg[IEF_TICK_OVF_FLAG_BIT])
                || (intCtrl_reg[IEF_EXT_PIN_EN_BIT] && intCtrl_reg[IEF_EXT_PIN_FLAG_BIT])
                || (intCtrl_reg[IEF_PORT_CHG_EN_BIT] && portPinArmed
                    && intCtrl_reg[IEF_PORT_CHG_FLAG_BIT]);
  assign periphSrc = intCtrl_reg[IEF_PERIPH_GRP_EN_BIT] && |(perEn_reg & perFlag_reg);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      coreIrqReq <= 1'b0;
    else
      coreIrqReq <= intCtrl_next[IEF_GLOBAL_EN_BIT] && (coreSrc || periphSrc);
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Read data is taken in the setup cycle so that prdata leaves a flop; a flag
  // raised during the access cycle itself shows on the next read.
  logic [31:0] readMux;
  always_comb
  begin
    readMux = IEF_READ_ZERO;
    case (paddr)
      IEF_ADDR_INTERRUPT_CONTROL: readMux[IEF_REG_W-1:0] = intCtrl_reg;
      IEF_ADDR_PERIPH_IRQ_ENABLE: readMux[IEF_REG_W-1:0] = perEn_reg;
      IEF_ADDR_PERIPH_IRQ_FLAGS: readMux[IEF_REG_W-1:0] = perFlag_reg;
      IEF_ADDR_PIN_CHANGE_MASK: readMux[IEF_PORT_W-1:0] = pinChangeMask_reg;
      IEF_ADDR_EXT_EDGE_SELECT: readMux[0] = extEdgeSelect_reg;
      default: readMux = IEF_READ_ZERO;
    endcase
  end

  // Cleared outside the access phase so a stale word never lingers on the bus.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= IEF_READ_ZERO;
    else if (rdSetup)
      prdata <= readMux;
    else
      prdata <= IEF_READ_ZERO;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  tick_flag_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tickTimerRollover |=> intCtrl_reg[IEF_TICK_OVF_FLAG_BIT])
    else $error("tick overflow flag not set");
  tick_flag_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (intCtrl_reg[IEF_TICK_OVF_FLAG_BIT] && !wrCtrl) |=> intCtrl_reg[IEF_TICK_OVF_FLAG_BIT])
    else $error("tick overflow flag dropped without write");
  ext_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (primed_reg && extEdgeSelect_reg && extSync_reg && !extPrev_reg) |=> intCtrl_reg[IEF_EXT_PIN_FLAG_BIT])
    else $error("rising edge missed");
  ext_flag_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (intCtrl_reg[IEF_EXT_PIN_FLAG_BIT] && !wrCtrl) |=> intCtrl_reg[IEF_EXT_PIN_FLAG_BIT])
    else $error("external flag dropped without write");
  port_change_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (primed_reg && portSync_reg != portPrev_reg) |=> intCtrl_reg[IEF_PORT_CHG_FLAG_BIT])
    else $error("port change flag not set");
  global_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !intCtrl_reg[IEF_GLOBAL_EN_BIT] |-> !coreIrqReq)
    else $error("request with global enable clear");
  periph_group_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (intCtrl_next[IEF_GLOBAL_EN_BIT] && intCtrl_reg[IEF_PERIPH_GRP_EN_BIT]
     && |(perEn_reg & perFlag_reg)) |=> coreIrqReq)
    else $error("peripheral request lost");
  periph_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (perFlag_reg & ~PERIPH_MASK) == IEF_RESET_BYTE && (perEn_reg & ~PERIPH_MASK) == IEF_RESET_BYTE)
    else $error("unimplemented peripheral bit set");
  wide_ovf_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wideTimerOverflow |=> perFlag_reg[IEF_WIDE_OVF_BIT])
    else $error("wide timer flag not set");

  port_flag_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (intCtrl_reg[IEF_PORT_CHG_FLAG_BIT] && !wrCtrl) |=> intCtrl_reg[IEF_PORT_CHG_FLAG_BIT])
    else $error("port change flag dropped without write");
  ext_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (primed_reg && !extEdgeSelect_reg && !extSync_reg && extPrev_reg)
    |=> intCtrl_reg[IEF_EXT_PIN_FLAG_BIT])
    else $error("falling edge missed");
  conv_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (convDone && PERIPH_MASK[IEF_CONV_DONE_BIT]) |=> perFlag_reg[IEF_CONV_DONE_BIT])
    else $error("conversion done flag not set");
  capcmp_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capcmpEvent && (capcmpMode != IEF_CCP_PWM) && PERIPH_MASK[IEF_CAPCMP_BIT])
    |=> perFlag_reg[IEF_CAPCMP_BIT])
    else $error("capture compare flag not set");
  capcmp_pwm_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (capcmpMode == IEF_CCP_PWM && !wrPerFlag && !perFlag_reg[IEF_CAPCMP_BIT])
    |=> !perFlag_reg[IEF_CAPCMP_BIT])
    else $error("capture compare flag set in pwm mode");
  cmp_one_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (primed_reg && (cmpSync_reg[0] != cmpPrev_reg[0])) |=> perFlag_reg[IEF_CMP_ONE_BIT])
    else $error("comparator one flag not set");
  cmp_two_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (primed_reg && (cmpSync_reg[1] != cmpPrev_reg[1])) |=> perFlag_reg[IEF_CMP_TWO_BIT])
    else $error("comparator two flag not set");
  period_match_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (periodMatch && PERIPH_MASK[IEF_PERIOD_MATCH_BIT]) |=> perFlag_reg[IEF_PERIOD_MATCH_BIT])
    else $error("period match flag not set");
  periph_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wrPerFlag |=> ((perFlag_reg & $past(perFlag_reg)) == $past(perFlag_reg)))
    else $error("peripheral flag dropped without write");
  en_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wrPerEn && wrByte[IEF_WIDE_OVF_BIT]) |=> perEn_reg[IEF_WIDE_OVF_BIT])
    else $error("wide timer enable not written");
  read_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (psel && penable && !pwrite && (paddr == IEF_ADDR_PERIPH_IRQ_FLAGS))
    |-> ((prdata[IEF_REG_W-1:0] & ~PERIPH_MASK) == IEF_RESET_BYTE))
    else $error("unimplemented flag bit read as one");

  // ----------------------------------------
  // Request gating
  // ----------------------------------------
  tick_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (intCtrl_next[IEF_GLOBAL_EN_BIT] && intCtrl_reg[IEF_TICK_OVF_EN_BIT]
     && intCtrl_reg[IEF_TICK_OVF_FLAG_BIT]) |=> coreIrqReq)
    else $error("enabled tick overflow lost");
  ext_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (intCtrl_next[IEF_GLOBAL_EN_BIT] && intCtrl_reg[IEF_EXT_PIN_EN_BIT]
     && intCtrl_reg[IEF_EXT_PIN_FLAG_BIT]) |=> coreIrqReq)
    else $error("enabled external pin event lost");
  periph_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!intCtrl_reg[IEF_PERIPH_GRP_EN_BIT] && !coreSrc) |=> !coreIrqReq)
    else $error("peripheral request with group enable clear");
  port_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pinChangeMask_reg == IEF_RESET_PORT && !intCtrl_reg[IEF_TICK_OVF_EN_BIT]
     && !intCtrl_reg[IEF_EXT_PIN_EN_BIT] && !periphSrc) |=> !coreIrqReq)
    else $error("port change request without armed pin");

endmodule : ief_irq_enable_flag_logic
`default_nettype wire

/* tb/ief_event_src.sv */
// Behavioural model of the timers, converter and comparators feeding the block
`timescale 1ns/100ps
`default_nettype none
module ief_event_src (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [2:0] evtSel,
  input wire logic evtGo,
  output logic tickTimerRollover,
  output logic convDone,
  output logic capcmpEvent,
  output logic periodMatch,
  output logic wideTimerOverflow,
  output logic comparatorOneOut,
  output logic comparatorTwoOut
);
  // ----------------------------------------
  // Clocked sources give one-cycle pulses
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      {tickTimerRollover, convDone, capcmpEvent, periodMatch, wideTimerOverflow} <= 5'h00;
    else
      {tickTimerRollover, convDone, capcmpEvent, periodMatch, wideTimerOverflow} <=
        evtGo ? (5'h10 >> evtSel) : 5'h00;

  // ----------------------------------------
  // Comparator outputs are levels; an event toggles one
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      {comparatorTwoOut, comparatorOneOut} <= 2'h0;
    else if (evtGo && evtSel >= 3'h5)
      {comparatorTwoOut, comparatorOneOut} <=
        {comparatorTwoOut, comparatorOneOut} ^ (2'h1 << (evtSel - 3'h5));
endmodule : ief_event_src
`default_nettype wire

/* tb/tb_irq_enable_flag_logic.sv */
// Self-checking testbench for the interrupt enable and flag block
`timescale 1ns/100ps
`default_nettype none
module tb_irq_enable_flag_logic import ief_pkg::*;;
  logic sysClk, rstN, psel, penable, pwrite, pready, pslverr, coreIrqReq, err, extIrqPin;
  logic tick, conv, capEv, perM, wideOv, cmp1, cmp2, evtGo;
  logic [2:0] evtSel;
  logic [1:0] capcmpMode;
  logic [5:0] firstIoPort, msk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] rd, ctl, pie, pir;
  logic [7:0] evtBit [7] = '{8'h04, 8'h40, 8'h20, 8'h02, 8'h01, 8'h08, 8'h10};
  int nFail = 0;
  int totalChecks = 0;

  ief_irq_enable_flag_logic dut_u (.sys_clk(sysClk), .rst_n(rstN), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tickTimerRollover(tick), .extIrqPin(extIrqPin),
    .firstIoPort(firstIoPort), .convDone(conv), .capcmpMode(capcmpMode),
    .capcmpEvent(capEv), .comparatorOneOut(cmp1), .comparatorTwoOut(cmp2),
    .periodMatch(perM), .wideTimerOverflow(wideOv), .coreIrqReq(coreIrqReq));
  ief_event_src evt_u (.sys_clk(sysClk), .rst_n(rstN), .evtSel(evtSel), .evtGo(evtGo),
    .tickTimerRollover(tick), .convDone(conv), .capcmpEvent(capEv), .periodMatch(perM),
    .wideTimerOverflow(wideOv), .comparatorOneOut(cmp1), .comparatorTwoOut(cmp2));

  initial
  begin
    sysClk = 1'b0;
    forever #12.5 sysClk = ~sysClk;
  end

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic finalReport();
    $display("checks=%0d mismatches=%0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finalReport

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nFail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({7'h00, got}, {7'h00, exp});
  endtask : chk_bit

  // Expected core request; the global enable gates peripheral pairs as well
  function automatic logic exp_irq(input logic [7:0] c, e, f, input logic [5:0] m);
    logic core;
    core = (c[5] & c[2]) | (c[4] & c[1]) | (c[3] & c[0] & (|m));
    return c[7] & (core | (c[6] & (|(e & f & IEF_PERIPH_MASK_FULL))));
  endfunction : exp_irq

  // ----------------------------------------
  // APB master; every task starts and ends just after a rising edge
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge sysClk);
    penable <= 1'b1;
    do
    begin
      @(posedge sysClk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      nFail++;
      finalReport();
    end
    @(posedge sysClk);
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk_reg(rd, exp);
  endtask : rdchk

  task automatic fire(input logic [2:0] s);
    evtSel <= s;
    evtGo <= 1'b1;
    @(posedge sysClk);
    evtGo <= 1'b0;
    repeat (6) @(posedge sysClk);
  endtask : fire

  initial
  begin
    {rstN, psel, penable, pwrite, evtGo, extIrqPin} <= 6'h00;
    {paddr, pwdata, evtSel, firstIoPort} <= '0;
    capcmpMode <= IEF_CCP_CAPTURE;
    void'($urandom(32'h37AE3952));
    repeat (5) @(posedge sysClk);
    rstN <= 1'b1;
    @(posedge sysClk);
    for (int a = 0; a < 5; a++)
      rdchk(12'(a * 4), 8'h00);
    chk_bit(coreIrqReq, 1'b0);
    apb(1'b0, 12'h014, 8'h00);
    chk_reg(rd, 8'h00);
    chk_bit(err, 1'b1);
    $display("test reset_and_map done");
    // Flags set with every enable off, then stay until software clears them
    for (int s = 0; s < 7; s++)
    begin
      fire(3'(s));
      repeat (8) @(posedge sysClk);
      rdchk(s ? IEF_ADDR_PERIPH_IRQ_FLAGS : IEF_ADDR_INTERRUPT_CONTROL, evtBit[s]);
      apb(1'b1, s ? IEF_ADDR_PERIPH_IRQ_FLAGS : IEF_ADDR_INTERRUPT_CONTROL, 8'h00);
    end
    capcmpMode <= IEF_CCP_COMPARE;
    fire(3'h2);
    rdchk(IEF_ADDR_PERIPH_IRQ_FLAGS, 8'h20);
    apb(1'b1, IEF_ADDR_PERIPH_IRQ_FLAGS, 8'h00);
    capcmpMode <= IEF_CCP_PWM;
    fire(3'h2);
    rdchk(IEF_ADDR_PERIPH_IRQ_FLAGS, 8'h00);
    capcmpMode <= 2'h3;
    fire(3'h2);
    rdchk(IEF_ADDR_PERIPH_IRQ_FLAGS, 8'h20);
    $display("test event_flags done");
    for (int e = 1; e >= 0; e--)
    begin
      apb(1'b1, IEF_ADDR_EXT_EDGE_SELECT, 8'(e));
      repeat (2)
      begin
        apb(1'b1, IEF_ADDR_INTERRUPT_CONTROL, 8'h00);
        extIrqPin <= ~extIrqPin;
        repeat (6) @(posedge sysClk);
        rdchk(IEF_ADDR_INTERRUPT_CONTROL, (extIrqPin == e) ? 8'h02 : 8'h00);
      end
      apb(1'b1, IEF_ADDR_INTERRUPT_CONTROL, 8'h00);
      firstIoPort <= firstIoPort ^ (6'h01 << ($urandom % 6));
      repeat (6) @(posedge sysClk);
      rdchk(IEF_ADDR_INTERRUPT_CONTROL, 8'h01);
    end
    $display("test pin_events done");
    // Gating: directed corners first, then random enable and flag mixes
    for (int i = 0; i < 40; i++)
    begin
      {ctl, pie, pir} = 24'($urandom);
      msk = 6'($urandom);
      if (i < 3)
        {ctl, pie, pir} = {(i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'hC0, 16'hFFFF};
      apb(1'b1, IEF_ADDR_INTERRUPT_CONTROL, 8'h00);
      apb(1'b1, IEF_ADDR_PIN_CHANGE_MASK, {2'h0, msk});
      apb(1'b1, IEF_ADDR_PERIPH_IRQ_ENABLE, pie);
      apb(1'b1, IEF_ADDR_PERIPH_IRQ_FLAGS, pir);
      apb(1'b1, IEF_ADDR_INTERRUPT_CONTROL, ctl);
      repeat (3) @(posedge sysClk);
      chk_bit(coreIrqReq, exp_irq(ctl, pie, pir, msk));
      rdchk(IEF_ADDR_PERIPH_IRQ_ENABLE, pie & IEF_PERIPH_MASK_FULL);
      rdchk(IEF_ADDR_PERIPH_IRQ_FLAGS, pir & IEF_PERIPH_MASK_FULL);
      rdchk(IEF_ADDR_INTERRUPT_CONTROL, ctl);
    end
    $display("test irq_gating done");
    finalReport();
  end
endmodule : tb_irq_enable_flag_logic
`default_nettype wire
